// *** hdl/fsds_top.sv ***
// front-panel status display sequencer of a redundant controller module
// Function
// RULE_01 - run: primary OK+node, backup B node
// RULE_02 - failed shows F file node; partner becomes primary
// RULE_03 - detailed: COMM flag word after failure word
// RULE_04 - comm RAM parity error shows code 0010
// RULE_05 - CTRL flag word follows comm code
// RULE_06 - control no-response shows code FFF3 after CTRL
// RULE_07 - blank then repeat detailed frame while enabled
// RULE_08 - non-detailed: failure word blinks with blank
// RULE_09 - only comm processor writes the display
// RULE_10 - comm watchdog expiry forces display blank
// RULE_11 - held detail switch overrides forced blanking
// RULE_12 - control watchdog expiry reported, no blanking
// RULE_13 - two-hex-digit step codes; 00 null, others spare
// RULE_14 - early step codes 02 05 07 09 0B
// RULE_15 - global DRAM steps 0D 0F 11 13 15
// RULE_16 - SRAM steps 17 19 1B 1D 1F 21
// RULE_17 - swap: primary shows SWAP, partner primary; code shows T step word if detailed and step latched
// RULE_18 - fixed dwell per word, equal blink phases
`default_nettype none
`include "fsds_regs.svh"
module fsds_top
	import fsds_pkg::*;
#(
	parameter int unsigned DWELL_CYCLES = `FSDS_DWELL_CYCLES
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic role_strap,
	input wire logic [7:0] primary_node_bcd,
	input wire logic [7:0] backup_node_bcd,
	input wire logic [3:0] file_digit,
	input wire logic detailed_mode,
	input wire logic detail_switch,
	input wire logic comm_wdt_expired,
	input wire logic ctrl_wdt_expired,
	input wire logic comm_parity_err,
	input wire logic ctrl_no_resp,
	input wire logic fail_evt,
	input wire logic partner_fail,
	input wire logic swap_cmd,
	input wire logic swap_done,
	input wire logic step_valid,
	input wire logic [7:0] step_code,
	input wire logic run_ready,
	output logic [31:0] disp_chars,
	output logic disp_blank,
	output logic role_primary,
	output logic fail_active,
	output logic step_spare
);
	fsds_link_if lnk ();

	fsds_dwell #(
		.DWELL_CYCLES(DWELL_CYCLES)
	) u_dwell (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.lnk(lnk.timer)
	);

	fsds_glyph u_glyph (
		.lnk(lnk.glyph)
	);

	// assigned step codes; 00 is the null step and anything unlisted is spare
	function automatic logic fsds_step_assigned(input logic [7:0] code);
		case (code)
			`FSDS_STEP_ROM_CSUM, `FSDS_STEP_CPU_REG, `FSDS_STEP_QUICK_DRAM,
			`FSDS_STEP_GDRAM_SYS, `FSDS_STEP_ASIC_REG: begin
				fsds_step_assigned = 1'b1; // [RULE_14]
			end
			`FSDS_STEP_GDRAM_SWEEP, `FSDS_STEP_GDRAM_PAT, `FSDS_STEP_GDRAM_DEC,
			`FSDS_STEP_GDRAM_INIT, `FSDS_STEP_GDRAM_EDC: begin
				fsds_step_assigned = 1'b1; // [RULE_15]
			end
			`FSDS_STEP_LSRAM_PAT, `FSDS_STEP_LSRAM_DEC, `FSDS_STEP_LSRAM_INIT,
			`FSDS_STEP_LSRAM_PAR, `FSDS_STEP_NSRAM_PAR, `FSDS_STEP_NSRAM_PAT: begin
				fsds_step_assigned = 1'b1; // [RULE_16]
			end
			default: fsds_step_assigned = 1'b0; // [RULE_13]
		endcase
	endfunction : fsds_step_assigned

	// role: strap caught on the first edge after reset release
	logic init_reg;
	logic init_next;
	logic primary_reg;
	logic primary_next;

	always_comb begin
		init_next = 1'b1;
		primary_next = primary_reg;
		if (!init_reg) begin
			primary_next = role_strap;
		end else if (fail_evt) begin
			primary_next = 1'b0; // [RULE_02]
		end else if (partner_fail && !primary_reg) begin
			primary_next = 1'b1; // [RULE_02]
		end else if (swap_cmd && primary_reg) begin
			primary_next = 1'b0; // [RULE_17]
		end else if (swap_cmd && !primary_reg) begin
			primary_next = 1'b1; // [RULE_17]
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			init_reg <= 1'b0;
			primary_reg <= `FSDS_RST_PRIMARY;
		end else begin
			init_reg <= init_next;
			primary_reg <= primary_next;
		end
	end

	// main state and failure frame phase
	fsds_state_t state_reg;
	fsds_state_t state_next;
	fsds_phase_t phase_reg;
	fsds_phase_t phase_next;
	logic swap_held_reg;
	logic swap_held_next;
	logic [7:0] step_reg;
	logic [7:0] step_next;
	logic [15:0] comm_code_reg;
	logic [15:0] comm_code_next;
	logic [15:0] ctrl_code_reg;
	logic [15:0] ctrl_code_next;

	always_comb begin
		state_next = state_reg;
		phase_next = phase_reg;
		swap_held_next = swap_held_reg;
		step_next = step_reg;
		comm_code_next = comm_code_reg;
		ctrl_code_next = ctrl_code_reg;
		if (comm_parity_err) begin
			comm_code_next = `FSDS_CODE_COMM_PARITY; // [RULE_04]
		end
		if (ctrl_no_resp) begin
			ctrl_code_next = `FSDS_CODE_CTRL_NORESP; // [RULE_06]
		end else if (ctrl_wdt_expired && ctrl_code_reg == `FSDS_CODE_NONE) begin
			ctrl_code_next = `FSDS_CODE_CTRL_WDT; // [RULE_12]
		end
		if (step_valid) begin
			step_next = step_code; // [RULE_13]
		end
		case (state_reg)
			ST_RUN: begin
				if (fail_evt) begin
					state_next = ST_FAIL; // [RULE_02]
					phase_next = PH_FWORD;
				end else if (swap_cmd && primary_reg) begin
					state_next = ST_SWAP; // [RULE_17]
					swap_held_next = 1'b0;
				end else if (step_valid) begin
					state_next = ST_TEST;
				end
			end
			ST_SWAP: begin
				if (fail_evt) begin
					state_next = ST_FAIL;
					phase_next = PH_FWORD;
				end else if (lnk.dwell_tick) begin
					swap_held_next = 1'b1; // [RULE_18]
				end
				if (!fail_evt && swap_held_reg && (swap_done || run_ready)) begin
					state_next = ST_RUN;
					step_next = `FSDS_STEP_NULL;
				end
			end
			ST_TEST: begin
				if (fail_evt) begin
					state_next = ST_FAIL;
					phase_next = PH_FWORD;
				end else if (run_ready) begin
					state_next = ST_RUN;
					step_next = `FSDS_STEP_NULL;
				end
			end
			ST_FAIL: begin
				// the frame only advances on dwell ticks, one word each
				if (lnk.dwell_tick) begin
					case (phase_reg)
						PH_FWORD: begin
							phase_next = detailed_mode ? PH_COMM : PH_BLANK; // [RULE_08]
						end
						PH_COMM: begin
							phase_next = detailed_mode ? PH_CCODE : PH_BLANK; // [RULE_04]
						end
						PH_CCODE: begin
							phase_next = detailed_mode ? PH_CTRL : PH_BLANK; // [RULE_05]
						end
						PH_CTRL: begin
							phase_next = detailed_mode ? PH_KCODE : PH_BLANK; // [RULE_06]
						end
						PH_KCODE: phase_next = PH_BLANK; // [RULE_07]
						PH_BLANK: phase_next = PH_FWORD; // [RULE_07]
						default: phase_next = PH_BLANK;
					endcase
				end
			end
			default: begin
				state_next = ST_RUN;
				phase_next = PH_FWORD;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			state_reg <= ST_RUN;
			phase_reg <= PH_FWORD;
			swap_held_reg <= 1'b0;
			step_reg <= `FSDS_RST_STEP;
			comm_code_reg <= `FSDS_CODE_NONE;
			ctrl_code_reg <= `FSDS_CODE_NONE;
		end else begin
			state_reg <= state_next;
			phase_reg <= phase_next;
			swap_held_reg <= swap_held_next;
			step_reg <= step_next;
			comm_code_reg <= comm_code_next;
			ctrl_code_reg <= ctrl_code_next;
		end
	end

	// word selection toward the glyph composer
	always_comb begin
		lnk.dwell_restart = (state_next != state_reg);
		lnk.node_bcd = primary_reg ? primary_node_bcd : backup_node_bcd;
		lnk.file_digit = file_digit;
		lnk.step_code = step_reg;
		lnk.hex_code = `FSDS_CODE_NONE;
		lnk.word_sel = W_BLANK;
		case (state_reg)
			ST_RUN: begin
				lnk.word_sel = primary_reg ? W_RUN : W_BACKUP; // [RULE_01]
			end
			ST_SWAP: begin
				if (detailed_mode && step_reg != `FSDS_STEP_NULL) begin
					lnk.word_sel = W_STEP;
				end else begin
					lnk.word_sel = W_SWAP; // [RULE_17]
				end
			end
			ST_TEST: begin
				if (detailed_mode && step_reg != `FSDS_STEP_NULL) begin
					lnk.word_sel = W_STEP; // [RULE_13]
				end else begin
					lnk.word_sel = W_STRT;
				end
			end
			ST_FAIL: begin
				lnk.node_bcd = primary_node_bcd; // [RULE_02]
				case (phase_reg)
					PH_FWORD: lnk.word_sel = W_FAIL; // [RULE_02]
					PH_COMM: lnk.word_sel = W_COMM; // [RULE_03]
					PH_CCODE: begin
						lnk.word_sel = W_CODE; // [RULE_04]
						lnk.hex_code = comm_code_reg;
					end
					PH_CTRL: lnk.word_sel = W_CTRL; // [RULE_05]
					PH_KCODE: begin
						lnk.word_sel = W_CODE; // [RULE_06]
						lnk.hex_code = ctrl_code_reg;
					end
					default: lnk.word_sel = W_BLANK; // [RULE_08]
				endcase
			end
			default: lnk.word_sel = W_BLANK;
		endcase
		// role not yet known on the first edge: no wrong word flashes up
		if (!init_reg) begin
			lnk.word_sel = W_BLANK; // [RULE_01]
		end
	end

	// output stage; comm watchdog blanks unless the detail switch is held
	logic force_blank;
	logic [31:0] disp_chars_reg;
	logic [31:0] disp_chars_next;
	logic disp_blank_reg;
	logic disp_blank_next;
	logic fail_active_reg;
	logic fail_active_next;
	logic step_spare_reg;
	logic step_spare_next;

	always_comb begin
		force_blank = comm_wdt_expired && !detail_switch; // [RULE_10] [RULE_11]
		disp_chars_next = lnk.word_chars; // [RULE_09]
		disp_blank_next = (lnk.word_sel == W_BLANK);
		if (force_blank) begin
			disp_chars_next = `FSDS_WORD_BLANK; // [RULE_10]
			disp_blank_next = 1'b1;
		end
		fail_active_next = (state_next == ST_FAIL);
		step_spare_next = (step_reg != `FSDS_STEP_NULL) && !fsds_step_assigned(step_reg);
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			disp_chars_reg <= `FSDS_WORD_BLANK;
			disp_blank_reg <= 1'b1;
			fail_active_reg <= 1'b0;
			step_spare_reg <= 1'b0;
		end else begin
			disp_chars_reg <= disp_chars_next;
			disp_blank_reg <= disp_blank_next;
			fail_active_reg <= fail_active_next;
			step_spare_reg <= step_spare_next;
		end
	end

	assign disp_chars = disp_chars_reg;
	assign disp_blank = disp_blank_reg;
	assign role_primary = primary_reg;
	assign fail_active = fail_active_reg;
	assign step_spare = step_spare_reg;
endmodule : fsds_top
`default_nettype wire

// *** inc/fsds_regs.svh ***
// constants of the failure status display sequencer
`ifndef FSDS_REGS_SVH
`define FSDS_REGS_SVH

`define FSDS_CLK_MHZ 200
`define FSDS_DWELL_TIME_MS 1000
`define FSDS_DWELL_CYCLES (`FSDS_DWELL_TIME_MS * 1000 * `FSDS_CLK_MHZ)

`define FSDS_CODE_NONE 16'h0000
`define FSDS_CODE_COMM_PARITY 16'h0010
`define FSDS_CODE_CTRL_NORESP 16'hFFF3
`define FSDS_CODE_CTRL_WDT 16'hFFF4

`define FSDS_STEP_NULL 8'h00
`define FSDS_STEP_ROM_CSUM 8'h02
`define FSDS_STEP_CPU_REG 8'h05
`define FSDS_STEP_QUICK_DRAM 8'h07
`define FSDS_STEP_GDRAM_SYS 8'h09
`define FSDS_STEP_ASIC_REG 8'h0B
`define FSDS_STEP_GDRAM_SWEEP 8'h0D
`define FSDS_STEP_GDRAM_PAT 8'h0F
`define FSDS_STEP_GDRAM_DEC 8'h11
`define FSDS_STEP_GDRAM_INIT 8'h13
`define FSDS_STEP_GDRAM_EDC 8'h15
`define FSDS_STEP_LSRAM_PAT 8'h17
`define FSDS_STEP_LSRAM_DEC 8'h19
`define FSDS_STEP_LSRAM_INIT 8'h1B
`define FSDS_STEP_LSRAM_PAR 8'h1D
`define FSDS_STEP_NSRAM_PAR 8'h1F
`define FSDS_STEP_NSRAM_PAT 8'h21

`define FSDS_CHAR_O 8'h4F
`define FSDS_CHAR_K 8'h4B
`define FSDS_CHAR_B 8'h42
`define FSDS_CHAR_F 8'h46
`define FSDS_CHAR_T 8'h54
`define FSDS_CHAR_SPACE 8'h20
`define FSDS_CHAR_DIGIT0 8'h30
`define FSDS_CHAR_ALPHA_OFS 8'h37

`define FSDS_WORD_BLANK 32'h20202020
`define FSDS_WORD_COMM 32'h434F4D4D
`define FSDS_WORD_CTRL 32'h4354524C
`define FSDS_WORD_SWAP 32'h53574150
`define FSDS_WORD_STRT 32'h53545254

`define FSDS_RST_PRIMARY 1'b0
`define FSDS_RST_STEP 8'h00

`endif

// *** inc/fsds_pkg.sv ***
// types of the failure status display sequencer
`default_nettype none
package fsds_pkg;
	typedef enum logic [3:0] {
		ST_RUN = 4'b0001,
		ST_SWAP = 4'b0010,
		ST_TEST = 4'b0100,
		ST_FAIL = 4'b1000
	} fsds_state_t;
	typedef enum logic [5:0] {
		PH_FWORD = 6'b000001,
		PH_COMM = 6'b000010,
		PH_CCODE = 6'b000100,
		PH_CTRL = 6'b001000,
		PH_KCODE = 6'b010000,
		PH_BLANK = 6'b100000
	} fsds_phase_t;
	typedef enum logic [3:0] {
		W_BLANK = 4'h0,
		W_RUN = 4'h1,
		W_BACKUP = 4'h2,
		W_FAIL = 4'h3,
		W_COMM = 4'h4,
		W_CTRL = 4'h5,
		W_CODE = 4'h6,
		W_SWAP = 4'h7,
		W_STEP = 4'h8,
		W_STRT = 4'h9
	} fsds_word_t;
endpackage : fsds_pkg
`default_nettype wire

// *** inc/fsds_link_if.sv ***
// internal link between sequencer, dwell timer and glyph composer
`default_nettype none
interface fsds_link_if
	import fsds_pkg::*;
;
	logic dwell_restart;
	logic dwell_tick;
	fsds_word_t word_sel;
	logic [7:0] node_bcd;
	logic [3:0] file_digit;
	logic [7:0] step_code;
	logic [15:0] hex_code;
	logic [31:0] word_chars;
	modport ctl (
		output dwell_restart, word_sel, node_bcd, file_digit, step_code, hex_code,
		input dwell_tick, word_chars
	);
	modport timer (
		input dwell_restart,
		output dwell_tick
	);
	modport glyph (
		input word_sel, node_bcd, file_digit, step_code, hex_code,
		output word_chars
	);
endinterface : fsds_link_if
`default_nettype wire

// *** hdl/fsds_dwell.sv ***
// dwell timer pacing each displayed word
`default_nettype none
`include "fsds_regs.svh"
module fsds_dwell
	import fsds_pkg::*;
#(
	parameter int unsigned DWELL_CYCLES = `FSDS_DWELL_CYCLES
) (
	input wire logic ref_clk,
	input wire logic resetn,
	fsds_link_if.timer lnk
);
	logic [31:0] count_reg;
	logic [31:0] count_next;
	logic tick_reg;
	logic tick_next;

	assign lnk.dwell_tick = tick_reg;

	// same period for every word, so blink on and off times match
	always_comb begin
		count_next = count_reg + 32'h00000001;
		tick_next = 1'b0;
		if (lnk.dwell_restart) begin
			count_next = 32'h00000000;
		end else if (count_reg >= DWELL_CYCLES - 1) begin
			count_next = 32'h00000000;
			tick_next = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			count_reg <= 32'h00000000;
			tick_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			tick_reg <= tick_next;
		end
	end
endmodule : fsds_dwell
`default_nettype wire

// *** hdl/fsds_glyph.sv ***
// composes the four display characters of a word
`default_nettype none
`include "fsds_regs.svh"
module fsds_glyph
	import fsds_pkg::*;
(
	fsds_link_if.glyph lnk
);
	function automatic logic [7:0] fsds_hex_char(input logic [3:0] nib);
		if (nib < 4'hA) begin
			fsds_hex_char = `FSDS_CHAR_DIGIT0 + {4'h0, nib};
		end else begin
			fsds_hex_char = `FSDS_CHAR_ALPHA_OFS + {4'h0, nib};
		end
	endfunction : fsds_hex_char

	always_comb begin
		case (lnk.word_sel)
			W_RUN: begin
				lnk.word_chars = {`FSDS_CHAR_O, `FSDS_CHAR_K,
					fsds_hex_char(lnk.node_bcd[7:4]), fsds_hex_char(lnk.node_bcd[3:0])};
			end
			W_BACKUP: begin
				lnk.word_chars = {`FSDS_CHAR_B, `FSDS_CHAR_SPACE,
					fsds_hex_char(lnk.node_bcd[7:4]), fsds_hex_char(lnk.node_bcd[3:0])};
			end
			W_FAIL: begin
				lnk.word_chars = {`FSDS_CHAR_F, fsds_hex_char(lnk.file_digit),
					fsds_hex_char(lnk.node_bcd[7:4]), fsds_hex_char(lnk.node_bcd[3:0])};
			end
			W_COMM: lnk.word_chars = `FSDS_WORD_COMM;
			W_CTRL: lnk.word_chars = `FSDS_WORD_CTRL;
			W_CODE: begin
				lnk.word_chars = {fsds_hex_char(lnk.hex_code[15:12]),
					fsds_hex_char(lnk.hex_code[11:8]),
					fsds_hex_char(lnk.hex_code[7:4]), fsds_hex_char(lnk.hex_code[3:0])};
			end
			W_SWAP: lnk.word_chars = `FSDS_WORD_SWAP;
			W_STEP: begin
				lnk.word_chars = {`FSDS_CHAR_T, `FSDS_CHAR_SPACE,
					fsds_hex_char(lnk.step_code[7:4]), fsds_hex_char(lnk.step_code[3:0])};
			end
			W_STRT: lnk.word_chars = `FSDS_WORD_STRT;
			default: lnk.word_chars = `FSDS_WORD_BLANK;
		endcase
	end
endmodule : fsds_glyph
`default_nettype wire

// *** verif/fsds_viewer.sv ***
// technician reading the front-panel display: flags each new word
`default_nettype none
`include "fsds_regs.svh"
module fsds_viewer
	import fsds_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [31:0] disp_chars,
	output logic seen,
	output logic [31:0] word
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] last_reg;
	logic [31:0] last_next;
	always_comb begin
		last_next = resetn ? disp_chars : `FSDS_WORD_BLANK;
	end
	always_ff @(posedge ref_clk) begin
		last_reg <= last_next;
	end
	// one pulse per change of the shown word
	assign seen = resetn && (disp_chars !== last_reg);
	assign word = disp_chars;
endmodule : fsds_viewer
`default_nettype wire

// *** verif/fsds_top_asserts.sv ***
// concurrent checks on the display sequencer ports
`default_nettype none
`include "fsds_regs.svh"
module fsds_asserts
	import fsds_pkg::*;
#(
	parameter int unsigned DWELL_CYCLES = 8
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic detail_switch,
	input wire logic comm_wdt_expired,
	input wire logic fail_evt,
	input wire logic partner_fail,
	input wire logic swap_cmd,
	input wire logic [31:0] disp_chars,
	input wire logic disp_blank,
	input wire logic role_primary,
	input wire logic fail_active
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] last_reg;
	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// cycles the current word has stood
	always_comb begin
		cnt_next = (disp_chars != last_reg) ? 32'h1 : cnt_reg + 32'h1;
	end
	always_ff @(posedge ref_clk) begin
		last_reg <= disp_chars;
		cnt_reg <= resetn ? cnt_next : 32'h0;
	end
	a_reset_blank: assert property (disable iff (1'b0) !resetn |=> disp_blank && !role_primary
		&& disp_chars == `FSDS_WORD_BLANK) else $error("display not blank in reset");
	a_wdt_blank: assert property (comm_wdt_expired && !detail_switch |=> disp_blank)
		else $error("watchdog expiry left display lit");
	a_switch_keep: assert property (comm_wdt_expired && detail_switch && !disp_blank
		&& !fail_active |=> !disp_blank) else $error("held switch did not keep display");
	a_fail_word: assert property (fail_evt && !fail_active |=> fail_active
		##1 disp_chars[31:24] == `FSDS_CHAR_F) else $error("failure word missing");
	a_fail_hold: assert property (fail_active |=> fail_active)
		else $error("failure state left without reset");
	a_swap_role: assert property (swap_cmd && role_primary && !fail_active && !fail_evt
		&& disp_chars[31:16] == 16'h4F4B |=> !role_primary) else $error("swap kept primary");
	a_partner_take: assert property (partner_fail && !role_primary && !fail_active
		&& !fail_evt |=> role_primary) else $error("backup did not take over");
	a_dwell_hold: assert property ($changed(disp_chars) && fail_active
		&& $past(fail_active, 3) |-> cnt_reg == DWELL_CYCLES || cnt_reg == DWELL_CYCLES + 1)
		else $error("word dwell length wrong");
endmodule : fsds_asserts
bind fsds_top fsds_asserts #(.DWELL_CYCLES(DWELL_CYCLES)) u_chk (.ref_clk(ref_clk),
	.resetn(resetn), .detail_switch(detail_switch), .comm_wdt_expired(comm_wdt_expired),
	.fail_evt(fail_evt), .partner_fail(partner_fail), .swap_cmd(swap_cmd),
	.disp_chars(disp_chars), .disp_blank(disp_blank), .role_primary(role_primary),
	.fail_active(fail_active));
`default_nettype wire

// *** verif/test_failure_status_display_sequencer.sv ***
// self-checking bench of the display sequencer
`default_nettype none
`include "fsds_regs.svh"
module test_failure_status_display_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	import fsds_pkg::*;
	logic ref_clk, resetn, role_strap, detailed_mode, detail_switch, comm_wdt_expired;
	logic ctrl_wdt_expired, comm_parity_err, ctrl_no_resp, fail_evt, partner_fail;
	logic swap_cmd, swap_done, step_valid, run_ready, seen, disp_blank;
	logic role_primary, fail_active, step_spare;
	logic [7:0] primary_node_bcd, backup_node_bcd, step_code;
	logic [3:0] file_digit;
	logic [31:0] disp_chars, word, rnd;
	logic [31:0] exp_q[$];
	logic [7:0] tbl[6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h21, 8'h22};
	int miscompares = 0;
	int compares = 0;
	localparam logic [31:0] RUN = 32'h4F4B3339;
	localparam logic [31:0] BKP = 32'h42203430;
	localparam logic [31:0] FW = 32'h46313339;
	fsds_top #(.DWELL_CYCLES(8)) u_dut (.ref_clk(ref_clk), .resetn(resetn),
		.role_strap(role_strap), .primary_node_bcd(primary_node_bcd),
		.backup_node_bcd(backup_node_bcd), .file_digit(file_digit),
		.detailed_mode(detailed_mode), .detail_switch(detail_switch),
		.comm_wdt_expired(comm_wdt_expired), .ctrl_wdt_expired(ctrl_wdt_expired),
		.comm_parity_err(comm_parity_err), .ctrl_no_resp(ctrl_no_resp), .fail_evt(fail_evt),
		.partner_fail(partner_fail), .swap_cmd(swap_cmd), .swap_done(swap_done),
		.step_valid(step_valid), .step_code(step_code), .run_ready(run_ready),
		.disp_chars(disp_chars), .disp_blank(disp_blank), .role_primary(role_primary),
		.fail_active(fail_active), .step_spare(step_spare));
	fsds_viewer u_view (.ref_clk(ref_clk), .resetn(resetn), .disp_chars(disp_chars),
		.seen(seen), .word(word));
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs
	task automatic end_of_test();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test
	task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t word exp=%h got=%h", $time, e, g);
		end
	endtask : cmp_word
	task automatic cmp_bit(input logic e, input logic g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t flag exp=%h got=%h", $time, e, g);
		end
	endtask : cmp_bit
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : tick
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask : pulse
	task automatic wait_q();
		for (int i = 0; i < 400 && exp_q.size() != 0; i++) tick(1);
		if (exp_q.size() != 0) begin
			miscompares++;
			$display("[ERR] %0t words left exp=%h got=%h", $time, exp_q[0], disp_chars);
			exp_q.delete();
		end
	endtask : wait_q
	task automatic do_reset(input logic strap);
		resetn = 1'b0;
		role_strap = strap;
		tick(8);
		resetn = 1'b1;
		tick(2);
	endtask : do_reset
	// any word change takes the oldest note; an unexpected change fails
	always @(posedge ref_clk) begin
		if (seen === 1'b1) begin
			if (exp_q.size() == 0) cmp_word(32'hFFFFFFFF, word);
			else cmp_word(exp_q.pop_front(), word);
		end
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		end_of_test();
	end
	initial begin
		{resetn, role_strap, detailed_mode, detail_switch, comm_wdt_expired} = '0;
		{ctrl_wdt_expired, comm_parity_err, ctrl_no_resp, fail_evt, partner_fail} = '0;
		{swap_cmd, swap_done, step_valid, run_ready, step_code} = '0;
		primary_node_bcd = 8'h39;
		backup_node_bcd = 8'h40;
		file_digit = 4'h1;
		rnd = 32'hA;
		tick(1);
		exp_q = '{RUN};
		do_reset(1'b1);
		wait_q();
		exp_q = '{`FSDS_WORD_BLANK};
		comm_wdt_expired = 1'b1;
		wait_q();
		exp_q = '{RUN};
		detail_switch = 1'b1;
		wait_q();
		exp_q = '{`FSDS_WORD_BLANK, RUN};
		detail_switch = 1'b0;
		tick(3);
		comm_wdt_expired = 1'b0;
		wait_q();
		pulse(ctrl_wdt_expired);
		tick(20);
		detailed_mode = 1'b1;
		step_code = 8'h17;
		exp_q = '{32'h54203137};
		pulse(step_valid);
		wait_q();
		exp_q = '{`FSDS_WORD_STRT};
		detailed_mode = 1'b0;
		wait_q();
		for (int i = 0; i < 16; i++) begin
			rnd = xs(rnd);
			step_code = (i < 6) ? tbl[i] : rnd[7:0];
			pulse(step_valid);
			tick(2);
			cmp_bit(step_code != 8'h00 && !(step_code == 8'h02 || (step_code[0]
				&& step_code >= 8'h05 && step_code <= 8'h21)), step_spare);
		end
		exp_q = '{RUN};
		pulse(run_ready);
		wait_q();
		exp_q = '{`FSDS_WORD_SWAP, BKP};
		pulse(swap_cmd);
		swap_done = 1'b1;
		wait_q();
		swap_done = 1'b0;
		exp_q = '{RUN};
		pulse(partner_fail);
		wait_q();
		pulse(comm_parity_err);
		pulse(ctrl_no_resp);
		detailed_mode = 1'b1;
		exp_q = '{FW, `FSDS_WORD_COMM, 32'h30303130, `FSDS_WORD_CTRL, 32'h46464633,
			`FSDS_WORD_BLANK, FW, `FSDS_WORD_COMM};
		pulse(fail_evt);
		wait_q();
		exp_q = '{`FSDS_WORD_BLANK, FW, `FSDS_WORD_BLANK, FW};
		detailed_mode = 1'b0;
		wait_q();
		cmp_bit(1'b1, fail_active);
		exp_q = '{BKP};
		do_reset(1'b0);
		wait_q();
		cmp_bit(1'b0, role_primary);
		// fresh codes: only the control watchdog reports, comm code stays null
		pulse(ctrl_wdt_expired);
		detailed_mode = 1'b1;
		exp_q = '{FW, `FSDS_WORD_COMM, 32'h30303030, `FSDS_WORD_CTRL, 32'h46464634};
		pulse(fail_evt);
		wait_q();
		end_of_test();
	end
endmodule : test_failure_status_display_sequencer
`default_nettype wire
